// ===== rtpc_pkg.sv
// package for the reload timer pwm and capture register block
// Function
// - output enable bits connect each pwm channel to pin
// - polarity zero: high while counter at or below compare
// - polarity change inverts output at once
// - duty register sets channel compare value
// - edge select: zero falling, one rising
// - capture irq enable gates each capture flag
// - capture flag set on capture, cleared by read
// - capture status upper two bits read zero
// - capture register holds counter, ignores writes
// - pwm, duty, capture registers reset to zero
// - overflow reloads counter and sets period-start level
// - no new capture until register read
// - capture input synchronised by two flip-flops
package rtpc_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_DUTY3 = 8'h31;
    localparam logic [7:0] OFS_DUTY2 = 8'h32;
    localparam logic [7:0] OFS_DUTY1 = 8'h33;
    localparam logic [7:0] OFS_DUTY0 = 8'h34;
    localparam logic [7:0] OFS_PWMCTL = 8'h35;
    localparam logic [7:0] OFS_TCSR = 8'h36;
    localparam logic [7:0] OFS_CNT = 8'h37;
    localparam logic [7:0] OFS_RELOAD = 8'h38;
    localparam logic [7:0] OFS_CAPCS = 8'h39;
    localparam logic [7:0] OFS_CAP1 = 8'h3A;
    localparam logic [7:0] OFS_CAP2 = 8'h3B;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h3C;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h3D;
    localparam logic [7:0] RESET_VAL = 8'h00;
    localparam logic [7:0] CNT_MAX = 8'hFF;
    // timer control/status fields
    localparam int TCSR_TCE = 3;
    localparam int TCSR_FCRL = 2;
    localparam int TCSR_OIE = 1;
    localparam int TCSR_OVF = 0;
    // capture control/status fields
    localparam int CAPCS_EDGE_LO = 4;
    localparam int CAPCS_IE_LO = 2;
    localparam int CAPCS_FLAG_LO = 0;
    // irq status bits: 0 overflow, 1 capture1, 2 capture2
    localparam int IRQ_W = 3;
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } rtpc_bus_t;
endpackage

// ===== rtpc_top.sv
// pwm outputs, input capture and register file of the 8-bit reload timer
//
// The implementer's own choice: the address-and-strobe port.
module rtpc_top
    import rtpc_pkg::*;
#(
    parameter int NCH = 4
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [1:0] capture_input_pin_in,
    output logic [7:0] rdata_out,
    output logic [NCH-1:0] pwm_out,
    output logic [NCH-1:0] pwm_oe_out,
    output logic irq_out
);
    rtpc_bus_t bus;
    logic [7:0] duty_value [NCH];
    logic [NCH-1:0] out_enable;
    logic [NCH-1:0] channel_polarity;
    logic [7:0] tcsr;
    logic [7:0] counter;
    logic [7:0] reload_value;
    logic [1:0] capture_edge_sel;
    logic [1:0] capture_irq_enable;
    logic [1:0] capture_flag;
    logic [7:0] captured_count [2];
    logic [1:0] cap_sync1, cap_sync2, cap_prev;
    logic [1:0] cap_event;
    logic [NCH-1:0] above;
    logic [IRQ_W-1:0] irq_stat, irq_mask, irq_set;
    logic overflow_flag;
    logic overflow;
    logic [7:0] next_rdata;

    assign bus = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};

    // counter runs on the cpu clock when enabled; prescaler lives elsewhere
    assign overflow = tcsr[TCSR_TCE] && (counter == CNT_MAX);

    // pwm control and duty registers, reset to zero
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            out_enable <= '0;
            channel_polarity <= '0;
            for (int i = 0; i < NCH; i++) begin
                duty_value[i] <= RESET_VAL;
            end
        end else if (bus.wr) begin
            if (bus.addr == OFS_PWMCTL) begin
                out_enable <= bus.wdata[7:4];
                channel_polarity <= bus.wdata[3:0];
            end
            // duty registers sit in reverse order: ch3 lowest
            for (int i = 0; i < NCH; i++) begin
                if (bus.addr == OFS_DUTY0 - 8'(i)) begin
                    duty_value[i] <= bus.wdata;
                end
            end
        end
    end

    // timer control, reload value; force-reload bit is never stored
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            tcsr <= RESET_VAL;
            reload_value <= RESET_VAL;
        end else if (bus.wr) begin
            if (bus.addr == OFS_TCSR) begin
                tcsr <= {bus.wdata[7:3], 1'b0, bus.wdata[1], 1'b0};
            end
            if (bus.addr == OFS_RELOAD) begin
                reload_value <= bus.wdata;
            end
        end
    end

    // overflow flag: set wins over the clear-on-read
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            overflow_flag <= 1'b0;
        end else if (overflow) begin
            overflow_flag <= 1'b1;
        end else if (bus.rd && bus.addr == OFS_TCSR) begin
            overflow_flag <= 1'b0;
        end
    end

    // counter: reload on overflow or forced reload, direct write allowed
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            counter <= RESET_VAL;
        end else if (bus.wr && bus.addr == OFS_TCSR && bus.wdata[TCSR_FCRL]) begin
            counter <= reload_value;
        end else if (bus.wr && bus.addr == OFS_CNT) begin
            counter <= bus.wdata;
        end else if (overflow) begin
            counter <= reload_value;
        end else if (tcsr[TCSR_TCE]) begin
            counter <= counter + 8'h01;
        end
    end

    // compare state per channel; set from the reload value on overflow (period start)
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            above <= '0;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (overflow) begin
                    above[i] <= (reload_value > duty_value[i]);
                end else begin
                    above[i] <= (counter > duty_value[i]);
                end
            end
        end
    end

    // polarity applied in the registered pwm_out stage so a polarity write acts at once
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            pwm_oe_out <= '0;
        end else begin
            pwm_oe_out <= out_enable;
        end
    end
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            pwm_out <= '0;
        end else begin
            // pwm_out sits low while the channel is disconnected
            pwm_out <= out_enable & (~above ^ channel_polarity);
        end
    end

    // capture input synchroniser; stage one is read by stage two only
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            cap_sync1 <= '0;
            cap_sync2 <= '0;
            cap_prev <= '0;
        end else begin
            cap_sync1 <= capture_input_pin_in;
            cap_sync2 <= cap_sync1;
            cap_prev <= cap_sync2;
        end
    end

    // rising when edge bit is one, falling when zero
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            cap_event[c] = capture_edge_sel[c] ? (cap_sync2[c] & ~cap_prev[c])
                                               : (~cap_sync2[c] & cap_prev[c]);
        end
    end

    // capture control bits
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            capture_edge_sel <= '0;
            capture_irq_enable <= '0;
        end else if (bus.wr && bus.addr == OFS_CAPCS) begin
            capture_edge_sel <= bus.wdata[CAPCS_EDGE_LO+:2];
            capture_irq_enable <= bus.wdata[CAPCS_IE_LO+:2];
        end
    end

    // flags and latched values; a held flag blocks further transfers
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            capture_flag <= '0;
            captured_count[0] <= RESET_VAL;
            captured_count[1] <= RESET_VAL;
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (cap_event[c] && !capture_flag[c]) begin
                    capture_flag[c] <= 1'b1;
                    captured_count[c] <= counter;
                end else if (bus.rd && bus.addr == OFS_CAP1 + 8'(c)) begin
                    capture_flag[c] <= 1'b0;
                end
            end
        end
    end

    // sticky interrupt status, write one to clear, set wins
    assign irq_set = {cap_event[1] & ~capture_flag[1],
                      cap_event[0] & ~capture_flag[0], overflow};
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            irq_stat <= '0;
            irq_mask <= '0;
        end else begin
            if (bus.wr && bus.addr == OFS_IRQ_MASK) begin
                irq_mask <= bus.wdata[IRQ_W-1:0];
            end
            if (bus.wr && bus.addr == OFS_IRQ_STAT) begin
                irq_stat <= (irq_stat & ~bus.wdata[IRQ_W-1:0]) | irq_set;
            end else begin
                irq_stat <= irq_stat | irq_set;
            end
        end
    end

    // interrupt also stays up while an enabled source flag is pending
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(irq_stat & irq_mask)
                     | |(capture_flag & capture_irq_enable)
                     | (overflow_flag & tcsr[TCSR_OIE]);
        end
    end

    // read mux; unmapped addresses return zero
    always_comb begin
        next_rdata = 8'h00;
        for (int i = 0; i < NCH; i++) begin
            if (bus.addr == OFS_DUTY0 - 8'(i)) begin
                next_rdata = duty_value[i];
            end
        end
        case (bus.addr)
            OFS_PWMCTL: next_rdata = {out_enable, channel_polarity};
            OFS_TCSR: next_rdata = {tcsr[7:1], overflow_flag};
            OFS_CNT: next_rdata = counter;
            OFS_RELOAD: next_rdata = reload_value;
            OFS_CAPCS: next_rdata = {2'b00, capture_edge_sel,
                                     capture_irq_enable, capture_flag};
            OFS_CAP1: next_rdata = captured_count[0];
            OFS_CAP2: next_rdata = captured_count[1];
            OFS_IRQ_STAT: next_rdata = {5'h00, irq_stat};
            OFS_IRQ_MASK: next_rdata = {5'h00, irq_mask};
            default: ;
        endcase
    end
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            rdata_out <= 8'h00;
        end else begin
            rdata_out <= bus.rd ? next_rdata : 8'h00;
        end
    end

    // assertions
    sequence s_cap_taken(int c);
        cap_event[c] && !capture_flag[c];
    endsequence

    AST_OE: assert property (@(posedge clk_in) disable iff (!rstn_in)
        ##1 pwm_oe_out == $past(out_enable)) else $error("oe mismatch");
    AST_POL: assert property (@(posedge clk_in) disable iff (!rstn_in)
        ##1 (pwm_out[0] == ($past(out_enable[0]) & ($past(~above[0]) ^ $past(channel_polarity[0])))))
        else $error("pwm level wrong");
    AST_POLFLIP: assert property (@(posedge clk_in) disable iff (!rstn_in)
        out_enable[0] && $past(out_enable[0])
        && $changed(channel_polarity[0]) && $stable(above[0])
        |=> $changed(pwm_out[0])) else $error("polarity not at once");
    AST_EXCEED: assert property (@(posedge clk_in) disable iff (!rstn_in)
        !overflow && counter > duty_value[0] |=> above[0]) else $error("compare late");
    AST_RSV: assert property (@(posedge clk_in) disable iff (!rstn_in)
        bus.rd && bus.addr == OFS_CAPCS |=> rdata_out[7:6] == 2'b00) else $error("reserved set");
    AST_FLAG: assert property (@(posedge clk_in) disable iff (!rstn_in)
        s_cap_taken(0) |=> capture_flag[0] && captured_count[0] == $past(counter))
        else $error("capture lost");
    AST_HOLD: assert property (@(posedge clk_in) disable iff (!rstn_in)
        capture_flag[1] |=> $stable(captured_count[1])) else $error("capture overwritten");
    AST_SYNC: assert property (@(posedge clk_in) disable iff (!rstn_in)
        capture_edge_sel[0] && !capture_flag[0] && $stable(capture_edge_sel[0])
        && !cap_sync2[0] ##1 cap_sync2[0] |=> capture_flag[0]) else $error("sync latency");
    AST_IRQ: assert property (@(posedge clk_in) disable iff (!rstn_in)
        capture_flag[0] && capture_irq_enable[0] |=> irq_out) else $error("irq missing");
    AST_RELOAD: assert property (@(posedge clk_in) disable iff (!rstn_in)
        overflow && !bus.wr |=> counter == $past(reload_value)) else $error("no reload");

    // the checks below follow one pattern: one behaviour, one label

    // armed for falling: pin seen high, then low, with the flag still free
    sequence s_fall_seen(int c);
        !capture_edge_sel[c] && cap_sync2[c]
        ##1 !capture_edge_sel[c] && !cap_sync2[c] && !capture_flag[c];
    endsequence

    // armed for rising: pin seen low, then high, with the flag still free
    sequence s_rise_seen(int c);
        capture_edge_sel[c] && !cap_sync2[c]
        ##1 capture_edge_sel[c] && cap_sync2[c] && !capture_flag[c];
    endsequence

    // armed for rising: pin seen high, then low; nothing may be taken
    sequence s_fall_unarmed(int c);
        capture_edge_sel[c] && cap_sync2[c]
        ##1 capture_edge_sel[c] && !cap_sync2[c] && !capture_flag[c];
    endsequence

    // software read of one capture value register
    sequence s_cap_read(int c);
        bus.rd && (bus.addr == OFS_CAP1 + 8'(c));
    endsequence

    // pwm control, first duty, capture control, flag, second capture value and timer control are zero once reset has been applied
    AST_RST: assert property (@(posedge clk_in)
        !rstn_in |=> out_enable == '0 && channel_polarity == '0 && duty_value[0] == RESET_VAL
        && capture_edge_sel == '0 && capture_irq_enable == '0 && capture_flag == '0
        && captured_count[1] == RESET_VAL && tcsr == RESET_VAL)
        else $error("reset value wrong");

    // falling edge on channel two with a free flag must raise it
    AST_FALL: assert property (@(posedge clk_in) disable iff (!rstn_in)
        s_fall_seen(1) |=> capture_flag[1])
        else $error("falling capture missed");

    // rising edge takes the count seen while the event stood
    AST_RISE: assert property (@(posedge clk_in) disable iff (!rstn_in)
        s_rise_seen(0) |=> capture_flag[0] && captured_count[0] == $past(counter))
        else $error("rising capture missed");

    // a falling edge must never be taken on channel one while rising is selected
    AST_WRONG_EDGE: assert property (@(posedge clk_in) disable iff (!rstn_in)
        s_fall_unarmed(0) |=> !capture_flag[0])
        else $error("capture on wrong edge");

    // reading the capture value register clears its flag
    AST_CLR: assert property (@(posedge clk_in) disable iff (!rstn_in)
        s_cap_read(0) ##0 capture_flag[0] |=> !capture_flag[0])
        else $error("flag not cleared");

    // without that read a set flag stays set
    AST_KEEP: assert property (@(posedge clk_in) disable iff (!rstn_in)
        capture_flag[1] && !(bus.rd && bus.addr == OFS_CAP2) |=> capture_flag[1])
        else $error("flag lost without read");

    // writes aimed at a capture value register leave it alone
    AST_RO: assert property (@(posedge clk_in) disable iff (!rstn_in)
        bus.wr && bus.addr == OFS_CAP1 && !cap_event[0] |=> $stable(captured_count[0]))
        else $error("capture value written");

    // with every enable and mask off the request line stays low
    AST_IRQ_OFF: assert property (@(posedge clk_in) disable iff (!rstn_in)
        capture_irq_enable == '0 && irq_mask == '0 && !tcsr[TCSR_OIE] |=> !irq_out)
        else $error("irq without enable");

    // a disconnected channel drives neither level nor enable
    AST_OE_OFF: assert property (@(posedge clk_in) disable iff (!rstn_in)
        !out_enable[1] |=> !pwm_out[1] && !pwm_oe_out[1])
        else $error("channel not released");

    // after an overflow the compare state matches the reloaded count
    AST_PERIOD: assert property (@(posedge clk_in) disable iff (!rstn_in)
        overflow && !bus.wr |=> above[0] == (counter > duty_value[0]))
        else $error("period start level wrong");

    // a duty write is the compare value on the next cycle
    AST_DUTY: assert property (@(posedge clk_in) disable iff (!rstn_in)
        bus.wr && bus.addr == OFS_DUTY0 |=> duty_value[0] == $past(bus.wdata))
        else $error("duty write lost");
endmodule

// ===== rtpc_pins.sv
// pin-side model: capture sources and the pwm pads with their pull-ups
module rtpc_pins
    import rtpc_pkg::*;
(
    input wire logic [1:0] cap_level_in,
    input wire logic [3:0] pwm_in,
    input wire logic [3:0] pwm_oe_in,
    output logic [1:0] capture_pin_out,
    output logic [3:0] pad_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // outside source, skewed so its edges never line up with the clock
    assign #3 capture_pin_out = cap_level_in;
    // a released pad floats up to the pull-up level, never the last driven value
    assign pad_out = (pwm_in & pwm_oe_in) | ~pwm_oe_in;
endmodule

// ===== rtpc_top_tb.sv
// self-checking bench for the pwm and capture register block
module rtpc_top_tb
    import rtpc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in = 1'b0;
    logic rstn_in = 1'b0;
    rtpc_bus_t bus = '0;
    logic [1:0] cap_level = 2'b10;
    logic [1:0] cap_pin;
    logic [7:0] rdata_out;
    logic [3:0] pwm_out, pwm_oe_out, pad, exp_pwm;
    logic irq_out;
    logic rd_q = 1'b0;
    logic [7:0] exp_q[$];
    logic [7:0] c1, c2, cnt, rl;
    logic [7:0] duty[4];
    int err_total = 0;
    int checks_done = 0;
    int cycles = 0;

    rtpc_top #(.NCH(4)) rtpc_top_inst (.clk_in(clk_in), .rstn_in(rstn_in),
        .addr_in(bus.addr), .wdata_in(bus.wdata), .wr_in(bus.wr), .rd_in(bus.rd),
        .capture_input_pin_in(cap_pin), .rdata_out(rdata_out), .pwm_out(pwm_out),
        .pwm_oe_out(pwm_oe_out), .irq_out(irq_out));
    rtpc_pins rtpc_pins_inst (.cap_level_in(cap_level), .pwm_in(pwm_out),
        .pwm_oe_in(pwm_oe_out), .capture_pin_out(cap_pin), .pad_out(pad));

    initial begin
        forever #4 clk_in = ~clk_in;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_in);
        bus.wr <= 1'b0;
    endtask

    // expectation is queued here, the monitor below consumes it
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        @(posedge clk_in);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge clk_in);
        bus.rd <= 1'b0;
    endtask

    // registered outputs lag a write by two edges; sample mid-cycle
    task automatic settle();
        repeat (3) @(posedge clk_in);
        @(negedge clk_in);
    endtask

    // leave room for the two-stage synchroniser and the capture edge
    task automatic pin(input logic [1:0] lvl);
        @(posedge clk_in);
        cap_level <= lvl;
        repeat (8) @(posedge clk_in);
    endtask

    // read data stands only in the cycle after the strobe
    always @(posedge clk_in) begin
        rd_q <= bus.rd & rstn_in;
    end
    always @(negedge clk_in) begin
        if (rd_q) begin
            check(rdata_out, exp_q.pop_front());
        end
    end

    // hang guard, well above the roughly 500 cycles the sequence needs
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            end_of_test();
        end
    end

    initial begin
        void'($urandom(47825));
        repeat (5) @(posedge clk_in);
        rstn_in <= 1'b1;
        // whole map after reset, plus one unmapped hole
        for (int a = 8'h31; a <= 8'h3D; a++) begin
            rd(8'(a), 8'h00);
        end
        rd(8'h50, 8'h00);
        // counter frozen at a random point; duties straddle it
        cnt = 8'(($urandom % 254) + 1);
        duty[0] = cnt - 8'h01;
        duty[1] = cnt;
        duty[2] = 8'($urandom);
        duty[3] = 8'hFF;
        wr(OFS_CNT, cnt);
        for (int i = 0; i < 4; i++) begin
            wr(OFS_DUTY0 - 8'(i), duty[i]);
            exp_pwm[i] = (cnt <= duty[i]);
        end
        for (int i = 0; i < 4; i++) begin
            rd(OFS_DUTY0 - 8'(i), duty[i]);
        end
        rd(OFS_CNT, cnt);
        wr(OFS_PWMCTL, 8'hF0);
        settle();
        check(pwm_oe_out, 4'hF);
        check(pwm_out, exp_pwm);
        wr(OFS_PWMCTL, 8'hFF);
        @(posedge clk_in);
        @(negedge clk_in);
        check(pwm_out, 4'(~exp_pwm));
        wr(OFS_PWMCTL, 8'h5F);
        settle();
        check(pwm_out, ~exp_pwm & 4'h5);
        check(pad, (~exp_pwm & 4'h5) | 4'hA);
        // free run until at least one overflow
        wr(OFS_IRQ_MASK, 8'h01);
        wr(OFS_TCSR, 8'h0A);
        repeat (300) @(posedge clk_in);
        @(negedge clk_in);
        check(irq_out, 1'b1);
        rd(OFS_TCSR, 8'h0B);
        wr(OFS_TCSR, 8'h00);
        // wrap from FF into a random reload, then stop one count later
        rl = 8'($urandom % 255);
        wr(OFS_RELOAD, rl);
        wr(OFS_CNT, CNT_MAX);
        wr(OFS_TCSR, 8'h08);
        wr(OFS_TCSR, 8'h00);
        cnt = rl + 8'h01;
        rd(OFS_RELOAD, rl);
        rd(OFS_CNT, cnt);
        settle();
        check(pwm_out, {1'b0, cnt > duty[2], 1'b0, cnt > duty[0]});
        // forced reload loads the count and reads back as zero
        wr(OFS_TCSR, 8'h04);
        rd(OFS_CNT, rl);
        rd(OFS_TCSR, 8'h01);
        rd(OFS_IRQ_STAT, 8'h01);
        wr(OFS_IRQ_STAT, 8'h07);
        wr(OFS_IRQ_MASK, 8'h00);
        // capture: ch1 on rising, ch2 on falling, both enables off
        c1 = 8'($urandom);
        c2 = ~c1;
        wr(OFS_CNT, c1);
        wr(OFS_CAPCS, 8'h10);
        pin(2'b01);
        rd(OFS_CAPCS, 8'h13);
        settle();
        check(irq_out, 1'b0);
        wr(OFS_IRQ_MASK, 8'h02);
        settle();
        check(irq_out, 1'b1);
        wr(OFS_IRQ_STAT, 8'h06);
        wr(OFS_IRQ_MASK, 8'h00);
        settle();
        check(irq_out, 1'b0);
        wr(OFS_CAPCS, 8'h14);
        settle();
        check(irq_out, 1'b1);
        // new edges while the flag is up must not overwrite
        wr(OFS_CNT, c2);
        pin(2'b00);
        pin(2'b01);
        rd(OFS_CAP1, c1);
        settle();
        check(irq_out, 1'b0);
        rd(OFS_CAPCS, 8'h16);
        rd(OFS_CAP2, c1);
        wr(OFS_CAP1, 8'hAA);
        rd(OFS_CAP1, c1);
        pin(2'b00);
        rd(OFS_CAPCS, 8'h14);
        pin(2'b01);
        rd(OFS_CAP1, c2);
        settle();
        end_of_test();
    end
endmodule
